// *** include/scrg_regs.svh ***
`ifndef SCRG_REGS_SVH
`define SCRG_REGS_SVH
// What this block does
// [R1] bus address in bits 7:1, rewritable
// [R2] host writes zero to address bit 0
// [R3] writing one to soft reset bit resets
// [R4] soft reset keeps the bus address
// [R5] pin 0 function: output bit, detect 0
// [R6] pin 1 function: por, bit1, detect1, lock
// [R7] pull field: off, down, up, reserved
// [R8] bit 1 enables pin input buffer
// [R9] bit 0 enables pin output driver
// [R10] host tristates inputs, disables output buffers
// [R11] device answers only while chip selected

// ==========================================
// register offsets
`define SCRG_OFS_BUS_ADDRESS 8'h00
`define SCRG_OFS_SOFT_RESET 8'h01
`define SCRG_OFS_PIN0_CONFIG 8'h02
`define SCRG_OFS_PIN1_CONFIG 8'h03

// ==========================================
// field positions
`define SCRG_ADDR_MSB 7
`define SCRG_ADDR_LSB 1
`define SCRG_SOFT_RESET_BIT 0
`define SCRG_CFG_MODE_MSB 7
`define SCRG_CFG_MODE_LSB 4
`define SCRG_CFG_PULL_MSB 3
`define SCRG_CFG_PULL_LSB 2
`define SCRG_CFG_IBUF_BIT 1
`define SCRG_CFG_OE_BIT 0

// ==========================================
// field codes and reset values
`define SCRG_PIN_CFG_RESET 8'h05
`define SCRG_PULL_NONE 2'h0
`define SCRG_PULL_DOWN 2'h1
`define SCRG_PULL_UP 2'h2
`define SCRG_MODE_0 4'h0
`define SCRG_MODE_1 4'h1
`define SCRG_MODE_2 4'h2
`define SCRG_MODE_3 4'h3
`define SCRG_READ_UNMAPPED 8'h00
`define SCRG_LAST_BIT 3'h7
`endif

// *** include/scrg_pkg.sv ***
package scrg_pkg;
   // serial target engine states
   typedef enum logic [2:0] {
      SCRG_IDLE = 3'b000,
      SCRG_ADDR = 3'b001,
      SCRG_PTR = 3'b010,
      SCRG_WDATA = 3'b011,
      SCRG_RDATA = 3'b100
   } scrg_state_e;
endpackage

// *** src/scrg_top.sv ***
`timescale 1ns/10ps
`include "scrg_regs.svh"
module scrg_top #(
   // power-up bus address; value is arbitrary
   parameter logic [6:0] BUS_ADDRESS_RESET = 7'h2A
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic bus_chip_select,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   input wire logic [1:0] general_output_bits,
   input wire logic signal_detect_0,
   input wire logic signal_detect_1,
   input wire logic cdr_lock,
   input wire logic power_on_status,
   output logic [1:0] pin_out,
   output logic [1:0] pin_oe_n,
   output logic [1:0] pin_pull_up,
   output logic [1:0] pin_pull_down,
   output logic [1:0] pin_input_buffer_enable,
   output logic soft_reset_pulse
);

   // ==========================================
   // bus line edges
   logic scl_q;
   logic sda_q;
   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;

   // inputs are already synchronous, one stage gives the previous level
   always_ff @(posedge clock) begin
      if (reset) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl_in;
         sda_q <= sda_in;
      end
   end

   assign scl_rise = scl_in & ~scl_q;
   assign scl_fall = ~scl_in & scl_q;
   assign bus_start = scl_in & scl_q & sda_q & ~sda_in;
   assign bus_stop = scl_in & scl_q & ~sda_q & sda_in;

   // ==========================================
   // register storage
   logic [6:0] bus_address_field_q;
   logic soft_reset_bit_q;
   logic [7:0] pin_config_q [2];
   logic [7:0] ptr_q;
   logic [7:0] shift_q;
   logic wr_fire;

   // read decode; reserved bits and unmapped offsets read as zero
   function automatic logic [7:0] reg_read(input logic [7:0] a);
      logic [7:0] r;
      r = `SCRG_READ_UNMAPPED;
      case (a)
         `SCRG_OFS_BUS_ADDRESS: r = {bus_address_field_q, 1'b0}; // [R1] [R2]
         `SCRG_OFS_SOFT_RESET: r = {7'h00, soft_reset_bit_q};
         `SCRG_OFS_PIN0_CONFIG: r = pin_config_q[0];
         `SCRG_OFS_PIN1_CONFIG: r = pin_config_q[1];
         default: r = `SCRG_READ_UNMAPPED;
      endcase
      return r;
   endfunction

   // address survives soft reset, only the hard reset restores it
   always_ff @(posedge clock) begin
      if (reset) begin
         bus_address_field_q <= BUS_ADDRESS_RESET;
      end else if (wr_fire && ptr_q == `SCRG_OFS_BUS_ADDRESS) begin
         bus_address_field_q <= shift_q[`SCRG_ADDR_MSB:`SCRG_ADDR_LSB]; // [R1] [R4]
      end
   end

   // soft reset bit self-clears one cycle later, as the reset it causes restores it
   always_ff @(posedge clock) begin
      if (reset || soft_reset_bit_q) begin
         soft_reset_bit_q <= 1'b0;
      end else if (wr_fire && ptr_q == `SCRG_OFS_SOFT_RESET) begin
         soft_reset_bit_q <= shift_q[`SCRG_SOFT_RESET_BIT]; // [R3]
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         soft_reset_pulse <= 1'b0;
      end else begin
         soft_reset_pulse <= soft_reset_bit_q; // [R3]
      end
   end

   // pin configuration, restored by either reset
   generate
      for (genvar i = 0; i < 2; i++) begin : g_cfg
         always_ff @(posedge clock) begin
            if (reset || soft_reset_bit_q) begin
               pin_config_q[i] <= `SCRG_PIN_CFG_RESET; // [R3] [R7] [R8] [R9]
            end else if (wr_fire && ptr_q == (`SCRG_OFS_PIN0_CONFIG + 8'(i))) begin
               pin_config_q[i] <= shift_q;
            end
         end
      end
   endgenerate

   // ==========================================
   // serial target engine
   scrg_pkg::scrg_state_e state_q;
   logic [3:0] bit_cnt_q;
   logic [7:0] tx_q;
   logic rw_q;
   logic match_q;
   logic master_ack_q;
   logic bit_seen_q;
   logic [7:0] rd_byte;

   // read data for the current pointer, taken whole so no select lands on a call
   assign rd_byte = reg_read(ptr_q);

   assign wr_fire = scl_fall && bit_seen_q && bit_cnt_q == {1'b0, `SCRG_LAST_BIT}
                    && state_q == scrg_pkg::SCRG_WDATA;

   // bits are taken on the rising scl edge, and the line is changed on the falling scl edge
   always_ff @(posedge clock) begin
      if (reset) begin
         state_q <= scrg_pkg::SCRG_IDLE;
         bit_cnt_q <= 4'h0;
         shift_q <= 8'h00;
         tx_q <= 8'h00;
         ptr_q <= 8'h00;
         rw_q <= 1'b0;
         match_q <= 1'b0;
         master_ack_q <= 1'b0;
         bit_seen_q <= 1'b0;
         sda_oe_n <= 1'b1;
      end else if (!bus_chip_select || bus_stop) begin
         state_q <= scrg_pkg::SCRG_IDLE; // [R11]
         bit_cnt_q <= 4'h0;
         bit_seen_q <= 1'b0;
         sda_oe_n <= 1'b1;
      end else if (bus_start) begin
         state_q <= scrg_pkg::SCRG_ADDR;
         bit_cnt_q <= 4'h0;
         bit_seen_q <= 1'b0;
         sda_oe_n <= 1'b1;
      end else if (scl_rise) begin
         bit_seen_q <= 1'b1;
         if (bit_cnt_q[3]) begin
            master_ack_q <= ~sda_in;
         end else begin
            shift_q <= {shift_q[6:0], sda_in};
         end
      end else if (scl_fall && bit_seen_q && state_q != scrg_pkg::SCRG_IDLE) begin
         // the scl fall that closes a start condition carries no bit, so it is not counted
         if (bit_cnt_q[3]) begin
            // acknowledge slot over: release and move on
            bit_cnt_q <= 4'h0;
            sda_oe_n <= 1'b1;
            case (state_q)
               scrg_pkg::SCRG_ADDR: begin
                  if (!match_q) begin
                     state_q <= scrg_pkg::SCRG_IDLE;
                  end else if (rw_q) begin
                     state_q <= scrg_pkg::SCRG_RDATA;
                     tx_q <= {rd_byte[6:0], 1'b0};
                     sda_oe_n <= rd_byte[7];
                  end else begin
                     state_q <= scrg_pkg::SCRG_PTR;
                  end
               end
               scrg_pkg::SCRG_PTR: begin
                  state_q <= scrg_pkg::SCRG_WDATA;
               end
               scrg_pkg::SCRG_RDATA: begin
                  if (master_ack_q) begin
                     tx_q <= {rd_byte[6:0], 1'b0};
                     sda_oe_n <= rd_byte[7];
                  end else begin
                     state_q <= scrg_pkg::SCRG_IDLE;
                  end
               end
               default: begin
                  state_q <= state_q;
               end
            endcase
         end else if (bit_cnt_q == {1'b0, `SCRG_LAST_BIT}) begin
            // eighth bit done: decide the acknowledge
            bit_cnt_q <= 4'h8;
            case (state_q)
               scrg_pkg::SCRG_ADDR: begin
                  match_q <= shift_q[7:1] == bus_address_field_q; // [R1] [R11]
                  rw_q <= shift_q[0];
                  sda_oe_n <= shift_q[7:1] != bus_address_field_q;
               end
               scrg_pkg::SCRG_PTR: begin
                  ptr_q <= shift_q;
                  sda_oe_n <= 1'b0;
               end
               scrg_pkg::SCRG_WDATA: begin
                  ptr_q <= ptr_q + 8'h01;
                  sda_oe_n <= 1'b0;
               end
               scrg_pkg::SCRG_RDATA: begin
                  ptr_q <= ptr_q + 8'h01;
                  sda_oe_n <= 1'b1;
               end
               default: begin
                  sda_oe_n <= 1'b1;
               end
            endcase
         end else begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
            if (state_q == scrg_pkg::SCRG_RDATA) begin
               sda_oe_n <= tx_q[7];
               tx_q <= {tx_q[6:0], 1'b0};
            end
         end
      end
   end

   // open-drain data line only ever pulls low
   always_ff @(posedge clock) begin
      sda_out <= 1'b0;
   end

   // ==========================================
   // pin function and pad controls
   logic [1:0] pin_src;

   // reserved codes drive low so nothing stray reaches the pin
   always_comb begin
      pin_src = 2'b00;
      case (pin_config_q[0][`SCRG_CFG_MODE_MSB:`SCRG_CFG_MODE_LSB])
         `SCRG_MODE_0: pin_src[0] = general_output_bits[0]; // [R5]
         `SCRG_MODE_1: pin_src[0] = signal_detect_0; // [R5]
         default: pin_src[0] = 1'b0;
      endcase
      case (pin_config_q[1][`SCRG_CFG_MODE_MSB:`SCRG_CFG_MODE_LSB])
         `SCRG_MODE_0: pin_src[1] = power_on_status; // [R6]
         `SCRG_MODE_1: pin_src[1] = general_output_bits[1]; // [R6]
         `SCRG_MODE_2: pin_src[1] = signal_detect_1; // [R6]
         `SCRG_MODE_3: pin_src[1] = cdr_lock; // [R6]
         default: pin_src[1] = 1'b0;
      endcase
   end

   // the device does not police contention; the host must pick input or output use
   generate
      for (genvar i = 0; i < 2; i++) begin : g_pad
         always_ff @(posedge clock) begin
            if (reset) begin
               pin_out[i] <= 1'b0;
               pin_oe_n[i] <= 1'b0;
               pin_pull_up[i] <= 1'b0;
               pin_pull_down[i] <= 1'b1;
               pin_input_buffer_enable[i] <= 1'b0;
            end else begin
               pin_out[i] <= pin_src[i];
               pin_oe_n[i] <= ~pin_config_q[i][`SCRG_CFG_OE_BIT]; // [R9] [R10]
               pin_pull_up[i] <= pin_config_q[i][`SCRG_CFG_PULL_MSB:`SCRG_CFG_PULL_LSB] == `SCRG_PULL_UP; // [R7]
               pin_pull_down[i] <= pin_config_q[i][`SCRG_CFG_PULL_MSB:`SCRG_CFG_PULL_LSB] == `SCRG_PULL_DOWN; // [R7]
               pin_input_buffer_enable[i] <= pin_config_q[i][`SCRG_CFG_IBUF_BIT]; // [R8]
            end
         end
      end
   endgenerate

endmodule

// *** dv/scrg_host.sv ***
`timescale 1ns/10ps
// ==========
// bus controller model: sda_h low pulls the shared line, high lets the pull-up win
module scrg_host (
   input wire logic clock,
   output logic scl,
   output logic sda_h,
   input wire logic sda
);
   initial begin
      scl = 1'b1;
      sda_h = 1'b1;
   end
   // data moves a clock after scl falls, so it never changes while scl is high
   task automatic bit_io(input logic b, output logic r);
      @(posedge clock);
      sda_h <= b;
      repeat (3) @(posedge clock);
      scl <= 1'b1;
      repeat (4) @(posedge clock);
      r = sda;
      scl <= 1'b0;
   endtask
   // d0 = 1 gives a start (also repeated), d0 = 0 gives a stop
   task automatic cond(input logic d0);
      @(posedge clock);
      sda_h <= d0;
      repeat (3) @(posedge clock);
      scl <= 1'b1;
      repeat (4) @(posedge clock);
      sda_h <= ~d0;
      repeat (4) @(posedge clock);
      scl <= ~d0;
   endtask
   // eight bits msb first, then the acknowledge bit
   task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic sa);
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], q[i]);
      end
      bit_io(1'b1, sa);
   endtask
   // one register write or read; a read ends with a nack, ok means all acks came
   task automatic acc(input logic [6:0] a, input logic [7:0] ofs, input logic rnw, input logic [7:0] d,
                      output logic [7:0] q, output logic ok);
      logic s0, s1, s2, s3;
      s2 = 1'b0;
      cond(1'b1);
      xfer({a, 1'b0}, q, s0);
      xfer(ofs, q, s1);
      if (rnw) begin
         cond(1'b1);
         xfer({a, 1'b1}, q, s2);
      end
      xfer(rnw ? 8'hFF : (ofs == 8'h00 ? {d[7:1], 1'b0} : d), q, s3);
      cond(1'b0);
      ok = !(s0 | s1 | s2 | (s3 & !rnw));
   endtask
endmodule

// *** dv/scrg_top_assertions.sv ***
`timescale 1ns/10ps
// ==========
// port checks on the serial target and pin outputs
module scrg_top_assertions (
   input wire logic clock,
   input wire logic reset,
   input wire logic bus_chip_select,
   input wire logic scl_in,
   input wire logic sda_out,
   input wire logic sda_oe_n,
   input wire logic [1:0] pin_oe_n,
   input wire logic [1:0] pin_pull_up,
   input wire logic [1:0] pin_pull_down,
   input wire logic [1:0] pin_input_buffer_enable,
   input wire logic soft_reset_pulse
);
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   // open drain: only ever pulls low
   sda_low_only_a: assert property (sda_out == 1'b0)
      else $error("sda_out high");
   cs_release_a: assert property (!bus_chip_select |=> sda_oe_n)
      else $error("sda held while deselected");
   // the line moves one clock after a detected scl fall, or on deselect
   sda_timing_a: assert property ($changed(sda_oe_n) |-> (!$past(scl_in) && $past(scl_in, 2)) || !$past(bus_chip_select))
      else $error("sda moved off the scl fall");
   pull_excl_a: assert property ((pin_pull_up & pin_pull_down) == 2'h0)
      else $error("both pulls on");
   pulse_single_a: assert property (soft_reset_pulse |=> !soft_reset_pulse)
      else $error("soft reset pulse too long");
   // pads follow the restored configs one clock after the pulse
   pulse_defaults_a: assert property (soft_reset_pulse |=> pin_oe_n == 2'h0 && pin_pull_down == 2'h3
      && pin_pull_up == 2'h0 && pin_input_buffer_enable == 2'h0)
      else $error("pins not default after soft reset");
   pulse_in_ack_a: assert property (soft_reset_pulse |-> !sda_oe_n)
      else $error("soft reset outside the data ack");
   reset_pins_a: assert property ($fell(reset) |-> pin_oe_n == 2'h0 && pin_input_buffer_enable == 2'h0)
      else $error("pins not default after reset");
endmodule

// *** dv/tb.sv ***
`timescale 1ns/10ps
// ==========
// bench: register defaults, pin fields, address move, soft reset, deselect
module tb;
   localparam logic [6:0] ADR = 7'h2A;
   localparam logic [6:0] NEW = 7'h31;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic cs = 1'b1;
   logic [5:0] s = 6'h00;
   logic scl, sda_h, sda_out, sda_oe_n, srp;
   logic [1:0] pin_out, pin_oe_n, pu, pd, ibuf;
   wire sda = sda_h & (sda_oe_n | sda_out);
   int num_errors = 0;
   int tests_run = 0;
   int pulses = 0;
   always #12.5 clock = ~clock;
   // soft reset pulses are counted, not waited for
   always @(posedge clock) begin
      if (srp === 1'b1) pulses++;
   end
   scrg_top #(.BUS_ADDRESS_RESET(ADR)) dut (.clock(clock), .reset(reset), .bus_chip_select(cs),
      .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .general_output_bits({s[3], s[0]}),
      .signal_detect_0(s[1]), .signal_detect_1(s[4]), .cdr_lock(s[5]), .power_on_status(s[2]),
      .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pull_up(pu), .pin_pull_down(pd),
      .pin_input_buffer_enable(ibuf), .soft_reset_pulse(srp));
   scrg_host host (.clock(clock), .scl(scl), .sda_h(sda_h), .sda(sda));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // read back n registers, offset 4 being unmapped
   task automatic t_regs(input logic [6:0] a, input int n);
      logic [7:0] d;
      logic ok;
      for (int i = 0; i < n; i++) begin
         host.acc(a, i[7:0], 1'b1, 8'h00, d, ok);
         check(d, i == 0 ? {a, 1'b0} : (i == 2 || i == 3 ? 8'h05 : 8'h00));
      end
   endtask
   // every pull code, then every function code against one-hot sources
   task automatic t_pins();
      logic [7:0] q;
      logic ok;
      check({pd, pu, ibuf, pin_oe_n}, 8'hC0);
      for (int p = 0; p < 4; p++) begin
         host.acc(ADR, 8'h03, 1'b0, {4'h0, p[1:0], p[0], ~p[0]}, q, ok);
         check({pu[1], pd[1], ibuf[1], pin_oe_n[1]}, {p == 2, p == 1, p[0], p[0]});
      end
      for (int p = 0; p < 2; p++) begin
         for (int m = 0; m < 3 + 2 * p; m++) begin
            host.acc(ADR, 8'h02 + p[7:0], 1'b0, {m[3:0], 4'h5}, q, ok);
            s <= 6'h01 << (2 * p + m);
            repeat (3) @(posedge clock);
            check(pin_out[p], m < 2 + 2 * p);
            s <= ~(6'h01 << (2 * p + m));
            repeat (3) @(posedge clock);
            check(pin_out[p], 1'b0);
         end
      end
   endtask
   // move the address, then soft reset: configs return, address stays
   task automatic t_soft_reset();
      logic [7:0] d;
      logic ok;
      host.acc(ADR, 8'h02, 1'b0, 8'h1A, d, ok);
      host.acc(ADR, 8'h00, 1'b0, {NEW, 1'b0}, d, ok);
      host.acc(ADR, 8'h00, 1'b1, 8'h00, d, ok);
      check(ok, 1'b0);
      host.acc(NEW, 8'h01, 1'b0, 8'h01, d, ok);
      check(pulses[7:0], 8'h01);
      t_regs(NEW, 4);
   endtask
   // deselected, the target must stay silent
   task automatic t_deselect();
      logic [7:0] d;
      logic ok;
      cs <= 1'b0;
      host.acc(NEW, 8'h02, 1'b1, 8'h00, d, ok);
      check(d, 8'hFF);
      check(ok, 1'b0);
      cs <= 1'b1;
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      t_pins();
      reset <= 1'b1;
      @(posedge clock);
      reset <= 1'b0;
      t_regs(ADR, 5);
      t_soft_reset();
      t_deselect();
      tally_and_finish();
   end
endmodule
bind scrg_top scrg_top_assertions chk (.clock, .reset, .bus_chip_select, .scl_in, .sda_out, .sda_oe_n,
   .pin_oe_n, .pin_pull_up, .pin_pull_down, .pin_input_buffer_enable, .soft_reset_pulse);
